// ==== hw/rhd_pkg.sv ====
/*
 Package for the root hub descriptor register bank: offsets, field positions,
 reset values and write masks.
 Assumes a simple word-wide register port on the controller's register clock.
*/
package rhd_pkg;
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 32;
   localparam int          PORT_CNT        = 15;
   localparam logic [7:0]  OFS_CAPS        = 8'h48;
   localparam logic [7:0]  OFS_PORT_CFG    = 8'h4c;
   // Capabilities field positions
   localparam int          CAP_PORTS_LSB   = 0;
   localparam int          CAP_PORTS_MSB   = 7;
   localparam int          CAP_PSM_BIT     = 8;
   localparam int          CAP_NPS_BIT     = 9;
   localparam int          CAP_CDEV_BIT    = 10;
   localparam int          CAP_OCRM_BIT    = 11;
   localparam int          CAP_NO_OVERCURRENT_PROTECTION_BIT    = 12;
   localparam int          CAP_POTPG_LSB   = 24;
   localparam int          CAP_POTPG_MSB   = 31;
   // Port config field positions
   localparam int          CFG_DR_LSB      = 0;
   localparam int          CFG_PORT_POWER_CONTROL_MASK_LSB    = 16;
   localparam logic [7:0]  PORTS_MIN       = 8'h01;
   localparam logic [7:0]  PORTS_MAX       = 8'h0f;
   localparam logic [31:0] CAPS_RESET      = 32'hff00_0902;
   localparam logic [31:0] PORT_CFG_RESET  = 32'h0006_0000;
   // Writable bits: power-good time, no_overcurrent_protection, ocrm, nps, psm
   localparam logic [31:0] CAPS_WR_MASK    = 32'hff00_1b00;
   // Bit 27 reads only; bit 0 of each half is reserved
   localparam logic [31:0] PORT_CFG_WR_MASK = 32'hf7fe_fffe;
endpackage : rhd_pkg

// ==== hw/rhd_port_power.sv ====
/*
 Per-port power switch state for one root hub port.
 Assumes one-cycle command pulses from the hub status/port status logic.
*/
`timescale 1ns/10ps
module rhd_port_power (
   input  wire logic i_clk,
   input  wire logic i_rst,
   input  wire logic i_no_switch,
   input  wire logic i_per_port_mode,
   input  wire logic i_mask,
   input  wire logic i_glob_set,
   input  wire logic i_glob_clr,
   input  wire logic i_port_set,
   input  wire logic i_port_clr,
   output logic      o_powered
);
   logic pwr_ff;
   logic nxt_pwr;
   wire  use_port = i_per_port_mode & i_mask;
   wire  g_on  = i_glob_set & (~i_per_port_mode | ~i_mask);
   wire  g_off = i_glob_clr & (~i_per_port_mode | ~i_mask);
   wire  p_on  = i_port_set & use_port;
   wire  p_off = i_port_clr & use_port;

   assign nxt_pwr = (g_on | p_on) ? 1'b1 : ((g_off | p_off) ? 1'b0 : pwr_ff);

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pwr_ff <= 1'b0;
      end else begin
         pwr_ff <= nxt_pwr;
      end
   end

   assign o_powered = i_no_switch | pwr_ff;
endmodule : rhd_port_power

// ==== hw/rhd_regs.sv ====
/*
 Root hub descriptor register bank: capabilities and port config registers,
 per-port power state and overcurrent report routing.
 One instance of the port power switch per possible port; ports above the
 reported count are held off and never report overcurrent.
 Assumes a single-cycle register port on i_clk and one-cycle power commands.
 Assumes overcurrent inputs already on i_clk, so they take no synchroniser.
 Assumes software does not rely on reserved bits reading back what it wrote.
*/
`timescale 1ns/10ps
module rhd_regs
   import rhd_pkg::*;
(
   input  wire logic                    i_clk,
   input  wire logic                    i_rst,
   input  wire logic                    i_wr,
   input  wire logic                    i_rd,
   input  wire logic [rhd_pkg::ADDR_W-1:0] i_addr,
   input  wire logic [rhd_pkg::DATA_W-1:0] i_wdata,
   input  wire logic                    i_glob_set,
   input  wire logic                    i_glob_clr,
   input  wire logic [rhd_pkg::PORT_CNT:1] i_port_set,
   input  wire logic [rhd_pkg::PORT_CNT:1] i_port_clr,
   input  wire logic [rhd_pkg::PORT_CNT:1] i_oc_port,
   output logic [rhd_pkg::DATA_W-1:0]   o_rdata,
   output logic [rhd_pkg::PORT_CNT:1]   o_port_power,
   output logic [rhd_pkg::PORT_CNT:1]   o_oc_status,
   output logic                         o_oc_global,
   output logic [rhd_pkg::PORT_CNT:1]   o_not_removable
);
   import rhd_pkg::*;

   // Register state
   logic [DATA_W-1:0]   caps_ff;
   logic [DATA_W-1:0]   cfg_ff;
   logic [DATA_W-1:0]   rdata_ff;
   logic [PORT_CNT:1]   oc_ff;

   // Next values
   logic [DATA_W-1:0]   nxt_caps;
   logic [DATA_W-1:0]   nxt_cfg;
   logic [DATA_W-1:0]   nxt_rdata;
   logic [PORT_CNT:1]   nxt_oc;

   // Address decode
   wire                 sel_caps;
   wire                 sel_cfg;
   wire                 sel_none;
   wire                 wr_caps;
   wire                 wr_cfg;
   wire                 rd_any;
   wire [DATA_W-1:0]    caps_merge;
   wire [DATA_W-1:0]    cfg_merge;

   // Capabilities fields as seen by the rest of the hub
   wire [7:0]           port_cnt_raw;
   wire [7:0]           port_cnt;
   wire                 cnt_low;
   wire                 cnt_high;
   wire                 no_switch;
   wire                 psm_bit;
   wire                 per_port;
   wire                 ocrm_bit;
   wire                 no_protect;
   wire                 oc_per_port;
   wire                 oc_collective;
   wire                 oc_any;

   // Read views
   wire [DATA_W-1:0]    caps_view;
   wire [DATA_W-1:0]    cfg_view;
   wire [DATA_W-1:0]    read_mux;

   // Per-port field slices, index n is port n
   wire [PORT_CNT:1]    pwr_mask;
   wire [PORT_CNT:1]    removable_fix;
   wire [PORT_CNT:1]    port_present;

   // Address decode, byte offsets on full words
   assign sel_caps = (i_addr == OFS_CAPS);
   assign sel_cfg  = (i_addr == OFS_PORT_CFG);
   assign sel_none = ~sel_caps & ~sel_cfg;
   assign wr_caps  = i_wr & sel_caps;
   assign wr_cfg   = i_wr & sel_cfg;
   assign rd_any   = i_rd;

   assign caps_merge = (i_wdata & CAPS_WR_MASK) | (caps_ff & ~CAPS_WR_MASK);
   // Reserved mask and flag bits stay at reset value whatever is written
   assign cfg_merge  = (i_wdata & PORT_CFG_WR_MASK) | (cfg_ff & ~PORT_CFG_WR_MASK);
   assign nxt_caps   = wr_caps ? caps_merge : caps_ff;
   assign nxt_cfg    = wr_cfg ? cfg_merge : cfg_ff;
   assign nxt_oc     = i_oc_port;

   assign port_cnt_raw = caps_ff[CAP_PORTS_MSB:CAP_PORTS_LSB];
   assign cnt_low      = (port_cnt_raw < PORTS_MIN);
   assign cnt_high     = (port_cnt_raw > PORTS_MAX);
   assign port_cnt     = cnt_low ? PORTS_MIN : (cnt_high ? PORTS_MAX : port_cnt_raw);

   assign no_switch    = caps_ff[CAP_NPS_BIT];
   assign psm_bit      = caps_ff[CAP_PSM_BIT];
   assign per_port     = ~no_switch & psm_bit;
   assign ocrm_bit     = caps_ff[CAP_OCRM_BIT];
   assign no_protect   = caps_ff[CAP_NO_OVERCURRENT_PROTECTION_BIT];
   assign oc_per_port   = ~no_protect & ocrm_bit;
   assign oc_collective = ~no_protect & ~ocrm_bit;

   assign caps_view = {caps_ff[DATA_W-1:CAP_CDEV_BIT+1], 1'b0, caps_ff[CAP_CDEV_BIT-1:CAP_PSM_BIT], port_cnt};
   // Reserved bits read back as stored, which the write mask pins at reset value
   assign cfg_view  = cfg_ff;
   assign read_mux  = sel_none ? {DATA_W{1'b0}} :
                      (sel_caps ? caps_view : cfg_view);
   // Read data holds until the next read strobe
   assign nxt_rdata = rd_any ? read_mux : rdata_ff;

   // One short process per register keeps reset values next to their state
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         caps_ff <= CAPS_RESET;
      end else begin
         caps_ff <= nxt_caps;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cfg_ff <= PORT_CFG_RESET;
      end else begin
         cfg_ff <= nxt_cfg;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rdata_ff <= {DATA_W{1'b0}};
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         oc_ff <= '0;
      end else begin
         oc_ff <= nxt_oc;
      end
   end

   // Registered read data: valid the cycle after the strobe
   assign o_rdata = rdata_ff;

   // Port-indexed views of the config fields; bit 0 of each half is reserved and skipped
   assign pwr_mask      = cfg_ff[CFG_PORT_POWER_CONTROL_MASK_LSB+PORT_CNT:CFG_PORT_POWER_CONTROL_MASK_LSB+1];
   assign removable_fix = cfg_ff[CFG_DR_LSB+PORT_CNT:CFG_DR_LSB+1];
   assign oc_any        = |(oc_ff & port_present);

   genvar p;
   generate
      for (p = 1; p <= PORT_CNT; p++) begin : g_port
         wire present;
         wire sw_always;
         wire glob_set;
         wire port_set;
         // Ports above the count do not exist: never powered, never report
         assign present          = (8'(p) <= port_cnt);
         assign port_present[p]  = present;
         assign sw_always        = no_switch & present;
         assign glob_set         = i_glob_set & present;
         // Clear commands need no gating: an absent port is already off
         assign port_set         = i_port_set[p] & present;
         rhd_port_power u_pwr (
            .i_clk           (i_clk),
            .i_rst           (i_rst),
            .i_no_switch     (sw_always),
            .i_per_port_mode (per_port),
            // Mask bit n to port n
            .i_mask          (pwr_mask[p]),
            .i_glob_set      (glob_set),
            .i_glob_clr      (i_glob_clr),
            .i_port_set      (port_set),
            .i_port_clr      (i_port_clr[p]),
            .o_powered       (o_port_power[p])
         );
         assign o_oc_status[p]     = oc_per_port & present & oc_ff[p];
         assign o_not_removable[p] = removable_fix[p];
      end
   endgenerate

   // Collective report: any present port in overcurrent raises the one flag
   assign o_oc_global = oc_collective & oc_any;
endmodule : rhd_regs

// ==== bench/rhd_regs_checker.sv ====
/* Port checker for the root hub descriptor bank.
 Assumes one clock domain and an async active-high reset. */
`timescale 1ns/10ps
module rhd_regs_checker
   import rhd_pkg::*;
(
   input wire logic              i_clk,
   input wire logic              i_rst,
   input wire logic              i_wr,
   input wire logic              i_rd,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] o_rdata,
   input wire logic [PORT_CNT:1] o_port_power,
   input wire logic [PORT_CNT:1] o_not_removable
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   wire cap_rd = i_rd && i_addr == OFS_CAPS;
   wire cfg_rd = i_rd && i_addr == OFS_PORT_CFG;
   AST_UNMAPPED: assert property (i_rd && !cap_rd && !cfg_rd |=> o_rdata == '0)
      else $error("unmapped read not zero");
   AST_CDEV: assert property (cap_rd |=> !o_rdata[CAP_CDEV_BIT])
      else $error("compound flag read high");
   AST_PORT_RANGE: assert property (cap_rd |=> o_rdata[7:0] inside {[PORTS_MIN:PORTS_MAX]})
      else $error("port count out of range");
   AST_PORT_FIXED: assert property (cap_rd |=> o_rdata[7:0] == 8'h02)
      else $error("port count changed");
   AST_MASK_RSV: assert property (cfg_rd |=> !o_rdata[CFG_PORT_POWER_CONTROL_MASK_LSB])
      else $error("reserved mask bit set");
   AST_DR_RSV: assert property (cfg_rd |=> !o_rdata[CFG_DR_LSB])
      else $error("reserved removable bit set");
   AST_RD_HOLD: assert property (!i_rd |=> $stable(o_rdata))
      else $error("read data moved without read");
   AST_NOT_REM: assert property (!i_wr ##1 (cfg_rd && !i_wr) |=> o_not_removable == o_rdata[15:1])
      else $error("removable flags differ from register");
   AST_POWER_LIMIT: assert property (o_port_power[PORT_CNT:3] == '0)
      else $error("port above count powered");
   cover property (cfg_rd);
   cover property (|o_port_power);
   cover property (cap_rd ##1 o_rdata[CAP_PSM_BIT]);
endmodule : rhd_regs_checker
bind rhd_regs rhd_regs_checker chk (.i_clk, .i_rst, .i_wr, .i_rd, .i_addr, .o_rdata, .o_port_power, .o_not_removable);

// ==== bench/tb_rhd_regs.sv ====
/* Self-checking bench for the root hub descriptor bank.
 Assumes rhd_pkg and the bound port checker. */
`timescale 1ns/10ps
module tb_rhd_regs;
   import rhd_pkg::*;
   logic              i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_glob_set = 0, i_glob_clr = 0, o_oc_global;
   logic [ADDR_W-1:0] i_addr = '0;
   logic [DATA_W-1:0] i_wdata = '0, o_rdata;
   logic [PORT_CNT:1] i_port_set = '0, i_port_clr = '0, i_oc_port = '0, o_port_power, o_oc_status, o_not_removable;
   int                num_errors = 0, n_compared = 0;
   rhd_regs uut (.i_clk, .i_rst, .i_wr, .i_rd, .i_addr, .i_wdata, .i_glob_set, .i_glob_clr, .i_port_set,
      .i_port_clr, .i_oc_port, .o_rdata, .o_port_power, .o_oc_status, .o_oc_global, .o_not_removable);
   initial forever #20 i_clk = ~i_clk;
   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(negedge i_clk);
      {i_wr, i_addr, i_wdata} = {1'b1, a, d};
      @(negedge i_clk);
      i_wr = 0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(negedge i_clk);
      {i_rd, i_addr} = {1'b1, a};
      @(negedge i_clk);
      i_rd = 0;
      chk(o_rdata, exp);
   endtask : rd
   // One-cycle power commands, then the port power state
   task automatic pw(input logic gs, input logic gc, input logic [14:0] ps, input logic [14:0] pc,
                     input logic [31:0] exp);
      @(negedge i_clk);
      {i_glob_set, i_glob_clr, i_port_set, i_port_clr} = {gs, gc, ps, pc};
      @(negedge i_clk);
      {i_glob_set, i_glob_clr, i_port_set, i_port_clr} = '0;
      chk(32'(o_port_power), exp);
   endtask : pw
   // Watchdog so a stuck run still reaches the verdict
   initial begin
      #1000000;
      num_errors++;
      end_sim();
   end
   initial begin
      repeat (16) @(posedge i_clk);
      @(negedge i_clk);
      i_rst = 0;
      rd(OFS_CAPS, 32'hff00_0902);
      rd(OFS_PORT_CFG, 32'h0006_0000);
      rd(8'h50, 32'h0);
      $display("test reset done");
      wr(OFS_CAPS, '1);
      rd(OFS_CAPS, 32'hff00_1b02);
      wr(OFS_PORT_CFG, '1);
      rd(OFS_PORT_CFG, 32'hf7fe_fffe);
      chk(32'(o_not_removable), 32'h7fff);
      $display("test access done");
      wr(OFS_CAPS, 32'h0);
      wr(OFS_PORT_CFG, 32'h0004_0000);
      pw(1, 0, 0, 0, 32'h3);
      pw(0, 1, 0, 0, 32'h0);
      wr(OFS_CAPS, 32'h100);
      pw(1, 0, 0, 0, 32'h1);
      pw(0, 0, '1, 0, 32'h3);
      pw(0, 1, 0, 0, 32'h2);
      pw(0, 0, 15'h1, 0, 32'h2);
      pw(0, 0, 0, '1, 32'h0);
      wr(OFS_CAPS, 32'h300);
      pw(0, 1, 0, '1, 32'h3);
      $display("test power done");
      i_oc_port = 15'h2;
      wr(OFS_CAPS, 32'h800);
      @(negedge i_clk);
      chk(32'({o_oc_global, o_oc_status}), 32'h2);
      wr(OFS_CAPS, 32'h0);
      @(negedge i_clk);
      chk(32'({o_oc_global, o_oc_status}), 32'h8000);
      wr(OFS_CAPS, 32'h1000);
      @(negedge i_clk);
      chk(32'({o_oc_global, o_oc_status}), 32'h0);
      $display("test overcurrent done");
      end_sim();
   end
endmodule : tb_rhd_regs
